/* src/ldd_pkg.sv */
// Purpose: Shared constants for the display decode and diagnostics bank.
// Assumes: Register access by a 16-bit command word, address in D12:D8.
// Notes: Diagnostic timing is a plain default.
package ldd_pkg;
  localparam logic [7:0] ADDR_DECODE = 8'h09;
  localparam logic [7:0] ADDR_POWER = 8'h0c;
  localparam logic [7:0] ADDR_FEATURE = 8'h0e;
  localparam logic [7:0] ADDR_SELF_CHECK = 8'h0f;
  localparam logic [7:0] ADDR_DIAG_FIRST = 8'h14;
  localparam logic [7:0] ADDR_DIAG_LAST = 8'h1b;
  localparam logic [7:0] ADDR_DIGIT_FIRST = 8'h01;
  localparam logic [7:0] ADDR_DIGIT_LAST = 8'h08;
  localparam int CMD_RW_BIT = 14;
  localparam int PWR_RUN_BIT = 0;
  localparam int PWR_KEEP_FEAT_BIT = 7;
  localparam int FEAT_HEX_SEL_BIT = 2;
  localparam int TST_LAMP_BIT = 0;
  localparam int TST_SHORT_BIT = 1;
  localparam int TST_OPEN_BIT = 2;
  localparam int TST_BUSY_BIT = 3;
  localparam int TST_ERR_BIT = 4;
  localparam int TST_ROPEN_BIT = 5;
  localparam int TST_RSHORT_BIT = 6;
  localparam logic [7:0] FEATURE_RESET = 8'h00;
  localparam logic [7:0] POWER_RESET = 8'h00;
  localparam logic [7:0] DECODE_RESET = 8'h00;
  localparam logic [7:0] TEST_RESET = 8'h00;
  localparam logic [7:0] SEG_ALL_ON = 8'hff;
  // Time given to one digit of a fault scan.
  localparam int SCAN_DIGIT_NS = 1000;
  localparam int CLK_NS = 8;
  localparam int SCAN_DIGIT_CYC = (SCAN_DIGIT_NS + CLK_NS - 1) / CLK_NS;
endpackage : ldd_pkg

/* src/ldd_char_decode.sv */
// Purpose: Maps one digit register byte to segment lines.
// Assumes: Segment order DP,A,B,C,D,E,F,G from bit 7 down.
// Notes: Purely combinational.
`timescale 1ns/100ps
`default_nettype none
module ldd_char_decode (
  input wire logic [7:0] digit_i,
  input wire logic decode_en_i,
  input wire logic hex_sel_i,
  output logic [7:0] seg_o
);
  logic [6:0] glyph;
  always_comb begin
    glyph = 7'h00;
    case (digit_i[3:0])
      4'h0: glyph = 7'h7e;
      4'h1: glyph = 7'h30;
      4'h2: glyph = 7'h6d;
      4'h3: glyph = 7'h79;
      4'h4: glyph = 7'h33;
      4'h5: glyph = 7'h5b;
      4'h6: glyph = 7'h5f;
      4'h7: glyph = 7'h70;
      4'h8: glyph = 7'h7f;
      4'h9: glyph = 7'h7b;
      4'ha: glyph = hex_sel_i ? 7'h77 : 7'h01;
      4'hb: glyph = hex_sel_i ? 7'h1f : 7'h4f;
      4'hc: glyph = hex_sel_i ? 7'h4e : 7'h37;
      4'hd: glyph = hex_sel_i ? 7'h3d : 7'h0e;
      4'he: glyph = hex_sel_i ? 7'h4f : 7'h67;
      default: glyph = hex_sel_i ? 7'h47 : 7'h00;
    endcase
    if (decode_en_i) begin
      seg_o = {digit_i[7], glyph};
    end else begin
      seg_o = digit_i;
    end
  end
endmodule : ldd_char_decode
`default_nettype wire

/* src/ldd_fault_scan.sv */
// Purpose: Runs the open/short LED scan over eight digits.
// Assumes: Per-LED fault levels arrive from the analog front end.
// Notes: Results land only when the scan ends.
`timescale 1ns/100ps
`default_nettype none
module ldd_fault_scan (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic chk_open_i,
  input wire logic chk_short_i,
  input wire logic [7:0] open_fault_scan_start_i,
  input wire logic [7:0] short_fault_scan_start_i,
  output logic busy_o,
  output logic any_err_o,
  output logic done_o,
  output logic [63:0] result_o
);
  typedef enum logic [0:0] {LDD_IDLE, LDD_RUN} ldd_scan_t;
  ldd_scan_t st_q, st_d;
  logic [15:0] tick_q, tick_d;
  logic [2:0] dig_q, dig_d;
  logic [63:0] acc_q, acc_d, res_q, res_d;
  logic err_q, err_d, done_q, done_d;
  logic [7:0] fault;
  always_comb begin
    st_d = st_q;
    tick_d = tick_q;
    dig_d = dig_q;
    acc_d = acc_q;
    res_d = res_q;
    err_d = err_q;
    done_d = 1'b0;
    fault = (chk_open_i ? open_fault_scan_start_i : 8'h00) |
            (chk_short_i ? short_fault_scan_start_i : 8'h00);
    case (st_q)
      LDD_IDLE: begin
        if (start_i) begin
          st_d = LDD_RUN;
          tick_d = 16'h0000;
          dig_d = 3'h0;
          acc_d = 64'h0;
        end
      end
      default: begin
        if (tick_q == 16'(ldd_pkg::SCAN_DIGIT_CYC - 1)) begin
          tick_d = 16'h0000;
          acc_d[dig_q*8 +: 8] = fault;
          if (dig_q == 3'h7) begin
            st_d = LDD_IDLE;
            res_d = acc_d;
            err_d = |acc_d;
            done_d = 1'b1;
          end else begin
            dig_d = dig_q + 3'h1;
          end
        end else begin
          tick_d = tick_q + 16'h0001;
        end
      end
    endcase
  end
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      st_q <= LDD_IDLE;
      tick_q <= 16'h0000;
      dig_q <= 3'h0;
      acc_q <= 64'h0;
      res_q <= 64'h0;
      err_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tick_q <= tick_d;
      dig_q <= dig_d;
      acc_q <= acc_d;
      res_q <= res_d;
      err_q <= err_d;
      done_q <= done_d;
    end
  end
  assign busy_o = (st_q == LDD_RUN);
  assign any_err_o = err_q;
  assign done_o = done_q;
  assign result_o = res_q;
endmodule : ldd_fault_scan
`default_nettype wire

/* src/ldd_regs.sv */
// Purpose: Register bank for decode, power state and self check.
// Assumes: A whole 16-bit command word arrives with a one-cycle strobe.
// Notes: Address sits in D12:D8, data in D7:D0.
`timescale 1ns/100ps
`default_nettype none
module ldd_regs (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic cmd_valid_i,
  input wire logic [15:0] cmd_word_i,
  input wire logic [2:0] scan_digit_i,
  input wire logic [7:0] open_fault_scan_start_i,
  input wire logic [7:0] short_fault_scan_start_i,
  input wire logic resistor_open_i,
  input wire logic resistor_short_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic [7:0] seg_o,
  output logic display_on_o,
  output logic [7:0] feature_o
);
  logic [7:0] digit_q [8];
  logic [7:0] digit_d [8];
  logic [7:0] dec_q, dec_d, pwr_q, pwr_d, feat_q, feat_d;
  logic [2:0] tst_q, tst_d;
  logic [7:0] rd_q, rd_d;
  logic rdv_q, rdv_d, start;
  logic [7:0] addr, wdata, selected, seg_raw, status;
  logic busy, any_err, scan_done;
  logic [63:0] diag;

  assign addr = {4'h0, cmd_word_i[11:8]} | (cmd_word_i[12] ? 8'h10 : 8'h00);
  assign wdata = cmd_word_i[7:0];
  assign selected = digit_q[scan_digit_i];

  ldd_char_decode u_dec (
    .digit_i(selected),
    .decode_en_i(dec_q[scan_digit_i]),
    .hex_sel_i(feat_q[ldd_pkg::FEAT_HEX_SEL_BIT]),
    .seg_o(seg_raw)
  );

  ldd_fault_scan u_scan (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .start_i(start),
    .chk_open_i(tst_q[ldd_pkg::TST_OPEN_BIT]),
    .chk_short_i(tst_q[ldd_pkg::TST_SHORT_BIT]),
    .open_fault_scan_start_i(open_fault_scan_start_i),
    .short_fault_scan_start_i(short_fault_scan_start_i),
    .busy_o(busy),
    .any_err_o(any_err),
    .done_o(scan_done),
    .result_o(diag)
  );

  always_comb begin
    status = {1'b0, resistor_short_i, resistor_open_i, any_err, busy,
              tst_q};
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      digit_d[i] = digit_q[i];
    end
    dec_d = dec_q;
    pwr_d = pwr_q;
    feat_d = feat_q;
    tst_d = tst_q;
    rd_d = rd_q;
    rdv_d = 1'b0;
    start = 1'b0;
    if (cmd_valid_i && !cmd_word_i[ldd_pkg::CMD_RW_BIT]) begin
      if (addr >= ldd_pkg::ADDR_DIGIT_FIRST &&
          addr <= ldd_pkg::ADDR_DIGIT_LAST) begin
        digit_d[3'(addr - ldd_pkg::ADDR_DIGIT_FIRST)] = wdata;
      end else if (addr == ldd_pkg::ADDR_DECODE) begin
        dec_d = wdata;
      end else if (addr == ldd_pkg::ADDR_POWER) begin
        pwr_d = wdata;
        if (!wdata[ldd_pkg::PWR_KEEP_FEAT_BIT]) begin
          feat_d = ldd_pkg::FEATURE_RESET;
        end
      end else if (addr == ldd_pkg::ADDR_FEATURE) begin
        feat_d = wdata;
      end else if (addr == ldd_pkg::ADDR_SELF_CHECK) begin
        // Scans only touch the self-check bits, never stored settings.
        tst_d = wdata[2:0];
        start = !busy && (wdata[ldd_pkg::TST_SHORT_BIT] ||
                          wdata[ldd_pkg::TST_OPEN_BIT]);
      end
    end else if (cmd_valid_i) begin
      rdv_d = 1'b1;
      if (addr >= ldd_pkg::ADDR_DIGIT_FIRST &&
          addr <= ldd_pkg::ADDR_DIGIT_LAST) begin
        rd_d = digit_q[3'(addr - ldd_pkg::ADDR_DIGIT_FIRST)];
      end else if (addr == ldd_pkg::ADDR_DECODE) begin
        rd_d = dec_q;
      end else if (addr == ldd_pkg::ADDR_POWER) begin
        rd_d = pwr_q;
      end else if (addr == ldd_pkg::ADDR_FEATURE) begin
        rd_d = feat_q;
      end else if (addr == ldd_pkg::ADDR_SELF_CHECK) begin
        rd_d = status;
      end else if (addr >= ldd_pkg::ADDR_DIAG_FIRST &&
                   addr <= ldd_pkg::ADDR_DIAG_LAST) begin
        rd_d = diag[3'(addr - ldd_pkg::ADDR_DIAG_FIRST)*8 +: 8];
      end else begin
        rd_d = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 8; i++) begin
        digit_q[i] <= 8'h00;
      end
      dec_q <= ldd_pkg::DECODE_RESET;
      pwr_q <= ldd_pkg::POWER_RESET;
      feat_q <= ldd_pkg::FEATURE_RESET;
      tst_q <= ldd_pkg::TEST_RESET[2:0];
      rd_q <= 8'h00;
      rdv_q <= 1'b0;
    end else begin
      digit_q <= digit_d;
      dec_q <= dec_d;
      pwr_q <= pwr_d;
      feat_q <= feat_d;
      tst_q <= tst_d;
      rd_q <= rd_d;
      rdv_q <= rdv_d;
    end
  end

  // Lamp check overrides shutdown so every segment lights for inspection.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      seg_o <= 8'h00;
      display_on_o <= 1'b0;
    end else begin
      seg_o <= tst_q[ldd_pkg::TST_LAMP_BIT] ? ldd_pkg::SEG_ALL_ON :
               seg_raw;
      display_on_o <= pwr_q[ldd_pkg::PWR_RUN_BIT] ||
                      tst_q[ldd_pkg::TST_LAMP_BIT];
    end
  end

  assign rd_data_o = rd_q;
  assign rd_valid_o = rdv_q;
  assign feature_o = feat_q;
  // The host is expected to poll the busy flag first; scan_done
  // marks when results become coherent.
  logic unused_done;
  assign unused_done = scan_done;
endmodule : ldd_regs
`default_nettype wire

/* testbench/ldd_regs_checker.sv */
// Purpose: Port assertions for the register bank.
// Assumes: Address is {D12,D11:D8} of the command word.
// Notes: Scan length is judged by the bench.
`timescale 1ns/100ps
`default_nettype none
module ldd_regs_checker (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic cmd_valid_i,
  input wire logic [15:0] cmd_word_i,
  input wire logic resistor_open_i,
  input wire logic resistor_short_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic display_on_o,
  input wire logic [7:0] feature_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  logic [4:0] a;
  logic rd;
  logic wr;
  assign a = cmd_word_i[12:8];
  assign rd = cmd_valid_i && cmd_word_i[14];
  assign wr = cmd_valid_i && !cmd_word_i[14];
  sequence scan_go;
    wr && a == 5'h0f && cmd_word_i[2:1] != 2'h0;
  endsequence
  sequence stat_rd;
    rd && a == 5'h0f;
  endsequence
  chk_read_answer: assert property (rd |=> rd_valid_o)
    else $error("read gave no answer");
  chk_write_silent: assert property (wr |=> !rd_valid_o)
    else $error("write gave a read answer");
  chk_power_run: assert property (wr && a == 5'h0c && cmd_word_i[0]
    |-> ##2 display_on_o) else $error("display not on after run write");
  chk_feat_restore: assert property (wr && a == 5'h0c && !cmd_word_i[7]
    |=> feature_o == 8'h00) else $error("feature not restored");
  chk_feat_keep: assert property (wr && a == 5'h0c && cmd_word_i[7]
    |=> $stable(feature_o)) else $error("feature changed on keep");
  chk_lamp_on: assert property (wr && a == 5'h0f && cmd_word_i[0]
    |-> ##2 display_on_o) else $error("lamp check did not light");
  chk_busy_seen: assert property (scan_go ##2 stat_rd |=> rd_data_o[3])
    else $error("busy flag low after scan start");
  chk_current_set_resistor_flags: assert property (stat_rd |=>
    rd_data_o[6] == $past(resistor_short_i) &&
    rd_data_o[5] == $past(resistor_open_i))
    else $error("resistor flags wrong");
endmodule : ldd_regs_checker
bind ldd_regs ldd_regs_checker u_chk (.mclk_i(mclk_i), .nrst_i(nrst_i),
  .cmd_valid_i(cmd_valid_i), .cmd_word_i(cmd_word_i),
  .resistor_open_i(resistor_open_i), .resistor_short_i(resistor_short_i),
  .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .display_on_o(display_on_o), .feature_o(feature_o));
`default_nettype wire

/* testbench/ldd_fault_model.sv */
// Purpose: Fault level source standing in for the LED front end.
// Assumes: Levels stay steady for a whole scan.
// Notes: Open and short patterns are disjoint so an OR is visible.
`timescale 1ns/100ps
`default_nettype none
module ldd_fault_model (
  input wire logic fault_en_i,
  output logic [7:0] open_fault_scan_start_o,
  output logic [7:0] short_fault_scan_start_o
);
  assign open_fault_scan_start_o = fault_en_i ? 8'h81 : 8'h00;
  assign short_fault_scan_start_o = fault_en_i ? 8'h18 : 8'h00;
endmodule : ldd_fault_model
`default_nettype wire

/* testbench/led_display_decode_and_diagnostics_tb.sv */
// Purpose: Register level tests of the decode and diagnostics bank.
// Assumes: One command per call, answer checked after the take edge.
// Notes: Fonts use the usual segment shapes in DP,A..G order.
`timescale 1ns/100ps
`default_nettype none
module led_display_decode_and_diagnostics_tb;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [15:0] cmd_word_i = 16'h0000;
  logic [2:0] scan_digit_i = 3'h0;
  logic fault_en = 1'b0;
  logic r_open = 1'b0;
  logic r_short = 1'b0;
  logic last_err = 1'b0;
  logic [7:0] lo, ls, rd_data_o, seg_o, feature_o;
  logic rd_valid_o, display_on_o;
  int num_errors = 0;
  int num_checks = 0;
  logic [15:0][7:0] fb = 128'h0067_0e37_4f01_7b7f_705f_5b33_796d_307e;
  logic [15:0][7:0] fh = 128'h474f_3d4e_1f77_7b7f_705f_5b33_796d_307e;
  always #4 mclk_i = ~mclk_i;
  ldd_fault_model fm (.fault_en_i(fault_en), .open_fault_scan_start_o(lo),
    .short_fault_scan_start_o(ls));
  ldd_regs dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_word_i(cmd_word_i), .scan_digit_i(scan_digit_i),
    .open_fault_scan_start_i(lo), .short_fault_scan_start_i(ls), .resistor_open_i(r_open),
    .resistor_short_i(r_short), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .seg_o(seg_o), .display_on_o(display_on_o),
    .feature_o(feature_o));
  task automatic chk(input string n, input logic [7:0] e,
      input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cmd(input logic r, input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    cmd_valid_i <= 1'b1;
    cmd_word_i <= {1'b0, r, 1'b0, a, d};
    @(posedge mclk_i);
    cmd_valid_i <= 1'b0;
    #1;
  endtask : cmd
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    cmd(1'b1, a, 8'h00);
    chk("rd_data_o", e, rd_data_o);
  endtask : rd
  // Reads are polled one by one, so the scan end is seen within two cycles.
  task automatic scan(input logic [7:0] t, input logic f, input logic [7:0] e);
    int k;
    @(posedge mclk_i);
    fault_en <= f;
    cmd(1'b0, 5'h0f, t);
    rd(5'h0f, t | 8'h08 | (last_err ? 8'h10 : 8'h00));
    k = 0;
    while (rd_data_o[3] !== 1'b0 && k < 700) begin
      cmd(1'b1, 5'h0f, 8'h00);
      k++;
    end
    // Each status poll spans two cycles, so the polls count half the scan.
    num_checks++;
    if (k != 4 * ldd_pkg::SCAN_DIGIT_CYC) begin
      num_errors++;
      $display("mismatch scan_polls expected %0d seen %0d",
               4 * ldd_pkg::SCAN_DIGIT_CYC, k);
    end
    chk("status", t | ((e != 8'h00) ? 8'h10 : 8'h00), rd_data_o);
    last_err = (e != 8'h00);
    for (int i = 0; i < 8; i++) begin
      rd(5'(i) + 5'h14, e);
    end
  endtask : scan
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  initial begin
    #160000;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    nrst_i <= 1'b1;
    rd(5'h0f, 8'h00);
    rd(5'h0d, 8'h00);
    chk("feature_o", 8'h00, feature_o);
    cmd(1'b0, 5'h09, 8'h25);
    rd(5'h09, 8'h25);
    for (int m = 0; m < 2; m++) begin
      cmd(1'b0, 5'h0e, m[0] ? 8'h04 : 8'h00);
      for (int n = 0; n < 16; n++) begin
        cmd(1'b0, 5'h01, {n[0], 3'h5, n[3:0]});
        @(posedge mclk_i);
        #1;
        chk("seg_o", {n[0], 7'h00} | (m[0] ? fh[n] : fb[n]), seg_o);
      end
    end
    @(posedge mclk_i);
    scan_digit_i <= 3'h1;
    cmd(1'b0, 5'h02, 8'ha5);
    @(posedge mclk_i);
    #1;
    chk("seg_o", 8'ha5, seg_o);
    // The display enable and segments settle one cycle after their register.
    cmd(1'b0, 5'h0c, 8'h81);
    chk("feature_o", 8'h04, feature_o);
    @(posedge mclk_i);
    #1;
    chk("display_on_o", 8'h01, {7'h00, display_on_o});
    cmd(1'b0, 5'h0c, 8'h00);
    chk("feature_o", 8'h00, feature_o);
    @(posedge mclk_i);
    #1;
    chk("display_on_o", 8'h00, {7'h00, display_on_o});
    cmd(1'b0, 5'h0f, 8'h01);
    @(posedge mclk_i);
    #1;
    chk("display_on_o", 8'h01, {7'h00, display_on_o});
    chk("seg_o", 8'hff, seg_o);
    cmd(1'b0, 5'h0f, 8'h00);
    @(posedge mclk_i);
    #1;
    chk("display_on_o", 8'h00, {7'h00, display_on_o});
    chk("seg_o", 8'ha5, seg_o);
    for (int k = 1; k < 3; k++) begin
      @(posedge mclk_i);
      r_open <= (k == 1);
      r_short <= (k == 2);
      rd(5'h0f, (k == 1) ? 8'h20 : 8'h40);
    end
    @(posedge mclk_i);
    r_short <= 1'b0;
    scan(8'h02, 1'b1, 8'h18);
    scan(8'h04, 1'b1, 8'h81);
    scan(8'h06, 1'b1, 8'h99);
    scan(8'h06, 1'b0, 8'h00);
    rd(5'h09, 8'h25);
    chk("seg_o", 8'ha5, seg_o);
    final_report();
  end
endmodule : led_display_decode_and_diagnostics_tb
`default_nettype wire
